// [gpab_params.svh]
`ifndef GPAB_PARAMS_SVH
`define GPAB_PARAMS_SVH
// Register word offsets (word indices compared with address[5:2], one aligned 32-bit word each)
`define GPAB_OFS_PULLUP_A 4'h0
`define GPAB_OFS_CHGEN_A 4'h1
`define GPAB_OFS_ANSEL_A 4'h2
`define GPAB_OFS_DATA_A 4'h3
`define GPAB_OFS_DIR_A 4'h4
`define GPAB_OFS_DATA_B 4'h5
`define GPAB_OFS_DIR_B 4'h6
`define GPAB_OFS_ANSEL_B 4'h7
`define GPAB_OFS_CTRL 4'h8
`define GPAB_OFS_STATUS 4'h9
// Implemented-bit masks
`define GPAB_MASK_A6 8'h3F
`define GPAB_MASK_ANSEL_A 8'h17
`define GPAB_MASK_DIR_A 8'h37
`define GPAB_MASK_B 8'hF0
`define GPAB_MASK_ANSEL_B 8'h30
// Reset values
`define GPAB_RST_PULLUP_A 8'h3F
`define GPAB_RST_CHGEN_A 8'h00
`define GPAB_RST_ANSEL_A 8'h17
`define GPAB_RST_DIR_A 8'h3F
`define GPAB_RST_DIR_B 8'hF0
`define GPAB_RST_ANSEL_B 8'h30
// Control register field positions
`define GPAB_CTRL_PU_DIS 0
`define GPAB_CTRL_CHG_GEN 1
`define GPAB_CTRL_MCLR_EN 2
`define GPAB_CTRL_FLAG 3
// Master clear pin and Timer0 clock pin
`define GPAB_PIN_MCLR 3
`define GPAB_PIN_T0CK 2
`endif

// [gpab_pkg.sv]
`default_nettype none
package gpab_pkg;
	// Avalon-MM request seen by the slave
	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [31:0] writedata;
	} gpab_req_t;
	// Programming interface override of port A pins 0 and 1
	typedef struct packed {
		logic active;
		logic [1:0] out;
		logic [1:0] oe;
	} gpab_prog_t;
	// Complete module state
	typedef struct packed {
		logic [7:0] pullup_enable_a;
		logic [7:0] change_int_enable_a;
		logic [7:0] analog_select_a;
		logic [7:0] latch_a;
		logic [7:0] direction_a;
		logic [7:0] latch_b;
		logic [7:0] direction_b;
		logic [7:0] analog_select_b;
		logic global_pullup_disable;
		logic change_int_global_enable;
		logic master_clear_enable;
		logic change_int_flag;
		logic [7:0] last_read_a;
		logic [7:0] sync1_a;
		logic [7:0] sync2_a;
		logic [7:0] sync1_b;
		logic [7:0] sync2_b;
		logic waitreq;
		logic [31:0] readdata;
		logic [5:0] pin_out_a;
		logic [5:0] pin_oe_a;
		logic [5:0] pullup_on_a;
		logic [7:0] pin_out_b;
		logic [7:0] pin_oe_b;
		logic irq;
		logic timer0_clk;
		logic [7:0] analog_en;
	} gpab_state_t;
endpackage
`default_nettype wire

// [gpab_port.sv]
`include "gpab_params.svh"
`default_nettype none
// How it works
// - Six port A pull-up enables, one each, reset to all ones.
// - Pull-ups act only while the global pull-up disable bit is clear, save the master clear pull-up on pin 3.
// - Master clear enable forces pin 3 pull-up on.
// - Bits 7:6 of pull-up and change enables read zero, ignore writes.
// - Six port A change enables, one each, reset to zero.
// - Change interrupt also needs the global change enable bit.
// - Analog-selected port A pin reads zero and goes to analog function.
// - Analog select leaves digital output driving untouched.
// - Port A analog select has bits 4 and 2:0, reset one, rest zero.
// - Analog select kills digital reads but leaves pull-up and the pin 2 Timer0 clock alone.
// - Timer0 clock on pin 2 follows the pad, regardless of direction.
// - Programming interface drives pins 0 and 1 apart from direction bits.
// - Port B direction one floats the pin, zero drives the latch.
// - Port B read returns pins; write is read-modify-write into latch.
// - Port B direction still drives analog pins; analog pins read zero.
// - Port B analog select zeros reads, enables analog, keeps output.
// - Enabled pin mismatches against last-read value set the change flag.
// - A pin set as output has its pull-up switched off.
// - Last-read latch is not reset; flag keeps setting after reset.
module gpab_port
	import gpab_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Avalon-MM slave
	input wire logic [5:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// Pads
	input wire logic [5:0] i_pin_a,
	input wire logic [7:0] i_pin_b,
	output logic [5:0] o_pin_out_a,
	output logic [5:0] o_pin_oe_a,
	output logic [5:0] o_pullup_on_a,
	output logic [7:0] o_pin_out_b,
	output logic [7:0] o_pin_oe_b,
	// Programming interface
	input wire logic i_prog_active,
	input wire logic [1:0] i_prog_out,
	input wire logic [1:0] i_prog_oe,
	// Peripheral side
	output logic o_change_int,
	output logic o_timer0_ext_clock_in,
	output logic [7:0] o_analog_en_a,
	output logic [7:0] o_analog_en_b
);
	gpab_state_t s_q;
	gpab_state_t s_d;
	gpab_req_t req;
	logic [7:0] rd_a;
	logic [7:0] rd_b;
	logic [7:0] wbyte;
	logic take;
	logic port_a_access;
	logic [7:0] mismatch;
	logic [7:0] rdata;

	// Request bundle and handshake: answer one cycle after the request appears
	assign req = '{read: i_read, write: i_write, address: i_address, writedata: i_writedata};
	assign take = (req.read | req.write) & ~s_q.waitreq;
	assign wbyte = req.writedata[7:0];
	assign port_a_access = take & (req.address[5:2] == `GPAB_OFS_DATA_A);

	// Digital reads: analog pins read zero, port B pins 3:0 are absent
	assign rd_a = {2'h0, s_q.sync2_a[5:0]} & ~s_q.analog_select_a;
	assign rd_b = s_q.sync2_b & ~s_q.analog_select_b & `GPAB_MASK_B;

	// Mismatch against the value captured at the last port A access
	assign mismatch = (rd_a ^ s_q.last_read_a) & s_q.change_int_enable_a;

	// Read mux
	always_comb begin
		case (req.address[5:2])
			`GPAB_OFS_PULLUP_A: rdata = s_q.pullup_enable_a;
			`GPAB_OFS_CHGEN_A: rdata = s_q.change_int_enable_a;
			`GPAB_OFS_ANSEL_A: rdata = s_q.analog_select_a;
			`GPAB_OFS_DATA_A: rdata = rd_a;
			`GPAB_OFS_DIR_A: rdata = s_q.direction_a;
			`GPAB_OFS_DATA_B: rdata = rd_b;
			`GPAB_OFS_DIR_B: rdata = s_q.direction_b;
			`GPAB_OFS_ANSEL_B: rdata = s_q.analog_select_b;
			`GPAB_OFS_CTRL: rdata = {5'h00, s_q.master_clear_enable, s_q.change_int_global_enable,
				s_q.global_pullup_disable};
			`GPAB_OFS_STATUS: rdata = {7'h00, s_q.change_int_flag};
			default: rdata = 8'h00;
		endcase
	end

	// Next state
	always_comb begin
		s_d = s_q;
		// Two-flop synchronisers on the pads
		s_d.sync1_a = {2'h0, i_pin_a};
		s_d.sync2_a = s_q.sync1_a;
		s_d.sync1_b = i_pin_b;
		s_d.sync2_b = s_q.sync1_b;
		s_d.waitreq = ~(req.read | req.write) | ~s_q.waitreq;
		if (req.read & s_q.waitreq) begin // Captured early so data stands while waitrequest is low
			s_d.readdata = {24'h000000, rdata};
		end
		// Register writes on the edge that ends the bus cycle
		if (take & req.write & i_byteenable[0]) begin
			case (req.address[5:2])
				`GPAB_OFS_PULLUP_A: s_d.pullup_enable_a = wbyte & `GPAB_MASK_A6;
				`GPAB_OFS_CHGEN_A: s_d.change_int_enable_a = wbyte & `GPAB_MASK_A6;
				`GPAB_OFS_ANSEL_A: s_d.analog_select_a = wbyte & `GPAB_MASK_ANSEL_A;
				`GPAB_OFS_DATA_A: s_d.latch_a = wbyte & `GPAB_MASK_A6;
				`GPAB_OFS_DIR_A: s_d.direction_a = (wbyte & `GPAB_MASK_DIR_A) | 8'h08;
				// Read-modify-write: unwritten bits 3:0 take rd_b, which always reads zero there
				`GPAB_OFS_DATA_B: s_d.latch_b = (wbyte & `GPAB_MASK_B) | (rd_b & ~`GPAB_MASK_B);
				`GPAB_OFS_DIR_B: s_d.direction_b = wbyte & `GPAB_MASK_B;
				`GPAB_OFS_ANSEL_B: s_d.analog_select_b = wbyte & `GPAB_MASK_ANSEL_B;
				`GPAB_OFS_CTRL: begin
					s_d.global_pullup_disable = wbyte[`GPAB_CTRL_PU_DIS];
					s_d.change_int_global_enable = wbyte[`GPAB_CTRL_CHG_GEN];
					s_d.master_clear_enable = wbyte[`GPAB_CTRL_MCLR_EN];
				end
				default: ;
			endcase
		end
		// Any port A access re-arms the comparison
		if (port_a_access) begin
			s_d.last_read_a = rd_a;
		end
		// Flag: software clears by writing one; a live mismatch wins over the clear
		if (take & req.write & i_byteenable[0] & (req.address[5:2] == `GPAB_OFS_STATUS) & wbyte[0]) begin
			s_d.change_int_flag = 1'b0;
		end
		if (|mismatch) begin
			s_d.change_int_flag = 1'b1;
		end
		// Pad drivers: programming override on pins 1:0
		s_d.pin_out_a = s_q.latch_a[5:0];
		s_d.pin_oe_a = ~s_q.direction_a[5:0] & 6'h37;
		if (i_prog_active) begin
			s_d.pin_out_a[1:0] = i_prog_out;
			s_d.pin_oe_a[1:0] = i_prog_oe;
		end
		// Pull-ups: global gate, output kills, master clear forces pin 3
		s_d.pullup_on_a = s_q.pullup_enable_a[5:0] & s_q.direction_a[5:0]
			& {6{~s_q.global_pullup_disable}};
		if (s_q.master_clear_enable) begin
			s_d.pullup_on_a[`GPAB_PIN_MCLR] = 1'b1;
		end
		s_d.pin_out_b = s_q.latch_b;
		s_d.pin_oe_b = ~s_q.direction_b & `GPAB_MASK_B;
		s_d.irq = s_q.change_int_flag & s_q.change_int_global_enable;
		// Timer0 sees the pad whatever the direction bit, so a driven latch clocks it
		s_d.timer0_clk = s_q.sync2_a[`GPAB_PIN_T0CK];
		s_d.analog_en = s_q.analog_select_a;
		// Reset: everything except the last-read latch and the pad synchronisers
		if (!i_reset_n) begin
			s_d.pullup_enable_a = `GPAB_RST_PULLUP_A;
			s_d.change_int_enable_a = `GPAB_RST_CHGEN_A;
			s_d.analog_select_a = `GPAB_RST_ANSEL_A;
			s_d.latch_a = 8'h00;
			s_d.direction_a = `GPAB_RST_DIR_A;
			s_d.latch_b = 8'h00;
			s_d.direction_b = `GPAB_RST_DIR_B;
			s_d.analog_select_b = `GPAB_RST_ANSEL_B;
			s_d.global_pullup_disable = 1'b1;
			s_d.change_int_global_enable = 1'b0;
			s_d.master_clear_enable = 1'b0;
			s_d.change_int_flag = |mismatch;
			s_d.waitreq = 1'b1;
			s_d.readdata = 32'h00000000;
			s_d.pin_out_a = 6'h00;
			s_d.pin_oe_a = 6'h00;
			s_d.pullup_on_a = 6'h00;
			s_d.pin_out_b = 8'h00;
			s_d.pin_oe_b = 8'h00;
			s_d.irq = 1'b0;
			s_d.timer0_clk = 1'b0;
			s_d.analog_en = 8'h00;
		end
	end

	// State register; the last-read latch deliberately survives reset
	always_ff @(posedge i_core_clk) begin
		s_q <= s_d;
	end

	// Outputs straight from flops
	assign o_readdata = s_q.readdata;
	assign o_waitrequest = s_q.waitreq;
	assign o_pin_out_a = s_q.pin_out_a;
	assign o_pin_oe_a = s_q.pin_oe_a;
	assign o_pullup_on_a = s_q.pullup_on_a;
	assign o_pin_out_b = s_q.pin_out_b;
	assign o_pin_oe_b = s_q.pin_oe_b;
	assign o_change_int = s_q.irq;
	assign o_timer0_ext_clock_in = s_q.timer0_clk;
	assign o_analog_en_a = s_q.analog_en;
	assign o_analog_en_b = s_q.analog_select_b;

	// Pull-up enables come out of reset all set
	property p_pullup_reset;
		@(posedge i_core_clk) !i_reset_n |=> s_q.pullup_enable_a == 8'h3F;
	endproperty
	a_pullup_reset: assert property (p_pullup_reset) else $error("pull-up enables not reset");
	property p_global_pu;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		s_q.global_pullup_disable && !s_q.master_clear_enable |=> o_pullup_on_a == 6'h00;
	endproperty
	a_global_pu: assert property (p_global_pu) else $error("pull-up on while globally disabled");
	property p_mclr_pu;
		@(posedge i_core_clk) disable iff (!i_reset_n) s_q.master_clear_enable |=> o_pullup_on_a[3];
	endproperty
	a_mclr_pu: assert property (p_mclr_pu) else $error("pin 3 pull-up off under master clear");
	property p_upper_zero;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		s_q.pullup_enable_a[7:6] == 2'b00 && s_q.change_int_enable_a[7:6] == 2'b00;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("unimplemented enable bits set");
	property p_ansel_bits;
		@(posedge i_core_clk) disable iff (!i_reset_n) (s_q.analog_select_a & 8'hE8) == 8'h00;
	endproperty
	a_ansel_bits: assert property (p_ansel_bits) else $error("unimplemented analog bits set");
	property p_irq_gate;
		@(posedge i_core_clk) disable iff (!i_reset_n) !s_q.change_int_global_enable |=> !o_change_int;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without global enable");
	property p_out_pu_off;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		!s_q.direction_a[0] |=> !o_pullup_on_a[0];
	endproperty
	a_out_pu_off: assert property (p_out_pu_off) else $error("pull-up left on an output");
	sequence s_mismatch;
		|mismatch;
	endsequence
	property p_flag_set;
		@(posedge i_core_clk) s_mismatch |=> s_q.change_int_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("mismatch did not set flag");
	property p_b_oe;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		!s_q.direction_b[7] |=> o_pin_oe_b[7] && o_pin_out_b[7] == $past(s_q.latch_b[7]);
	endproperty
	a_b_oe: assert property (p_b_oe) else $error("port B output not driven");

	// Change enables come out of reset clear
	property p_chgen_reset;
		@(posedge i_core_clk) !i_reset_n |=> s_q.change_int_enable_a == 8'h00;
	endproperty
	a_chgen_reset: assert property (p_chgen_reset) else $error("change enables not reset");
	// Analog selects come out of reset on the implemented bits
	property p_ansel_reset;
		@(posedge i_core_clk) !i_reset_n |=> s_q.analog_select_a == 8'h17;
	endproperty
	a_ansel_reset: assert property (p_ansel_reset) else $error("analog selects not reset");
	// Port B pins come out of reset as inputs
	property p_dirb_reset;
		@(posedge i_core_clk) !i_reset_n |=> s_q.direction_b == 8'hF0;
	endproperty
	a_dirb_reset: assert property (p_dirb_reset) else $error("port B direction not reset");
	// Pull-ups are globally off after reset
	property p_pu_dis_reset;
		@(posedge i_core_clk) !i_reset_n |=> s_q.global_pullup_disable;
	endproperty
	a_pu_dis_reset: assert property (p_pu_dis_reset) else $error("global pull-up disable not set");
	// Analog-selected port A pins never read as one
	property p_read_zero_a;
		@(posedge i_core_clk) disable iff (!i_reset_n) (rd_a & s_q.analog_select_a) == 8'h00;
	endproperty
	a_read_zero_a: assert property (p_read_zero_a) else $error("analog pin read nonzero");
	// Port A analog enables follow the select register one cycle later
	property p_analog_en_a;
		@(posedge i_core_clk) disable iff (!i_reset_n) 1'b1 |=> o_analog_en_a == $past(s_q.analog_select_a);
	endproperty
	a_analog_en_a: assert property (p_analog_en_a) else $error("analog enable mismatch");
	// Output enables of pins 5:2 follow the direction bits, pin 3 never driven
	property p_oe_a;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		1'b1 |=> o_pin_oe_a[5:2] == (~$past(s_q.direction_a[5:2]) & 4'hD);
	endproperty
	a_oe_a: assert property (p_oe_a) else $error("port A enable mismatch");
	// Latch drives pins 5:2 whatever the analog selection
	property p_out_a;
		@(posedge i_core_clk) disable iff (!i_reset_n) 1'b1 |=> o_pin_out_a[5:2] == $past(s_q.latch_a[5:2]);
	endproperty
	a_out_a: assert property (p_out_a) else $error("port A drive mismatch");
	// Programming interface owns pin 0 and 1 enables
	property p_prog_oe;
		@(posedge i_core_clk) disable iff (!i_reset_n) i_prog_active |=> o_pin_oe_a[1:0] == $past(i_prog_oe);
	endproperty
	a_prog_oe: assert property (p_prog_oe) else $error("programming enable ignored");
	// Programming interface owns pin 0 and 1 levels
	property p_prog_out;
		@(posedge i_core_clk) disable iff (!i_reset_n) i_prog_active |=> o_pin_out_a[1:0] == $past(i_prog_out);
	endproperty
	a_prog_out: assert property (p_prog_out) else $error("programming drive ignored");
	// Absent port B pins are never driven
	property p_b_low_oe;
		@(posedge i_core_clk) disable iff (!i_reset_n) o_pin_oe_b[3:0] == 4'h0;
	endproperty
	a_b_low_oe: assert property (p_b_low_oe) else $error("absent port B pin driven");
	// Port B input direction floats the pin
	property p_b_in;
		@(posedge i_core_clk) disable iff (!i_reset_n) s_q.direction_b[6] |=> !o_pin_oe_b[6];
	endproperty
	a_b_in: assert property (p_b_in) else $error("port B input driven");
	// Timer0 clock follows the synchronised pad of pin 2
	property p_timer0;
		@(posedge i_core_clk) disable iff (!i_reset_n) 1'b1 |=> o_timer0_ext_clock_in == $past(s_q.sync2_a[2]);
	endproperty
	a_timer0: assert property (p_timer0) else $error("timer clock not following pad");
	// Interrupt line is the flag gated by the global enable
	property p_irq_level;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		1'b1 |=> o_change_int == $past(s_q.change_int_flag && s_q.change_int_global_enable);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");
	// Flag holds until software writes the status register
	property p_flag_hold;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		s_q.change_int_flag && !(take && req.write && req.address[5:2] == `GPAB_OFS_STATUS) |=> s_q.change_int_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");
	// Clear with no live mismatch empties the flag
	property p_flag_clear;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		take && req.write && i_byteenable[0] && req.address[5:2] == `GPAB_OFS_STATUS && wbyte[0] && !(|mismatch)
			|=> !s_q.change_int_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");
	// A port A access captures the value read
	property p_last_read;
		@(posedge i_core_clk) disable iff (!i_reset_n) port_a_access |=> s_q.last_read_a == $past(rd_a);
	endproperty
	a_last_read: assert property (p_last_read) else $error("last-read value not captured");
	// Waitrequest is low for a single cycle only
	property p_wait_pulse;
		@(posedge i_core_clk) disable iff (!i_reset_n) !o_waitrequest |=> o_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
	// No request keeps waitrequest high
	property p_wait_idle;
		@(posedge i_core_clk) disable iff (!i_reset_n) !i_read && !i_write |=> o_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low when idle");
	// A pending request is answered on the next cycle
	property p_answer;
		@(posedge i_core_clk) disable iff (!i_reset_n) (i_read || i_write) && o_waitrequest |=> !o_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	// Read data carries a byte only
	property p_read_data;
		@(posedge i_core_clk) disable iff (!i_reset_n) i_read && o_waitrequest |=> o_readdata[31:8] == 24'h000000;
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data upper bits set");
	// Pin 5 pull-up off while it is an output
	property p_pu_output5;
		@(posedge i_core_clk) disable iff (!i_reset_n) !s_q.direction_a[5] |=> !o_pullup_on_a[5];
	endproperty
	a_pu_output5: assert property (p_pu_output5) else $error("pin 5 pull-up on an output");
	// With pull-ups allowed, enables pass straight through on inputs
	property p_pu_follow;
		@(posedge i_core_clk) disable iff (!i_reset_n) !s_q.global_pullup_disable && !s_q.master_clear_enable
			|=> o_pullup_on_a == $past(s_q.pullup_enable_a[5:0] & s_q.direction_a[5:0]);
	endproperty
	a_pu_follow: assert property (p_pu_follow) else $error("pull-up not following enable");
	// Port B latch write keeps only the implemented data bits
	property p_rmw_b;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		take && req.write && i_byteenable[0] && req.address[5:2] == `GPAB_OFS_DATA_B
			|=> s_q.latch_b == ($past(i_writedata[7:0]) & 8'hF0);
	endproperty
	a_rmw_b: assert property (p_rmw_b) else $error("port B latch write mismatch");
	// Port B analog select keeps its unimplemented bits clear
	property p_analog_select_b_bits;
		@(posedge i_core_clk) disable iff (!i_reset_n) (s_q.analog_select_b & 8'hCF) == 8'h00;
	endproperty
	a_analog_select_b_bits: assert property (p_analog_select_b_bits) else $error("unimplemented port B analog bits");
endmodule
`default_nettype wire

// [gpab_pins_model.sv]
`default_nettype none
// Pads of both ports with whatever stands outside them
module gpab_pins_model (
	// Clock for the floating-line pattern
	input wire logic i_clk,
	// Device drive
	input wire logic [5:0] i_out_a,
	input wire logic [5:0] i_oe_a,
	input wire logic [5:0] i_pu_a,
	input wire logic [7:0] i_out_b,
	input wire logic [7:0] i_oe_b,
	// Outside sources
	input wire logic [5:0] i_ext_a,
	input wire logic [5:0] i_ext_en_a,
	input wire logic [7:0] i_ext_b,
	input wire logic [7:0] i_ext_en_b,
	// Resolved pad levels
	output logic [5:0] o_pad_a,
	output logic [7:0] o_pad_b
);
	logic flt = 1'b0;
	// An undriven line toggles so a stale level never passes for data
	always @(posedge i_clk) flt <= ~flt;
	// Device driver first, then outside source, then pull-up
	assign o_pad_a = (i_oe_a & i_out_a) | (~i_oe_a & i_ext_en_a & i_ext_a)
		| (~i_oe_a & ~i_ext_en_a & (i_pu_a | {6{flt}}));
	// Port B pads carry no pull-up in this block
	assign o_pad_b = (i_oe_b & i_out_b) | (~i_oe_b & i_ext_en_b & i_ext_b) | (~i_oe_b & ~i_ext_en_b & {8{flt}});
endmodule
`default_nettype wire

// [port_a_b_pin_control_tb_top.sv]
`include "gpab_params.svh"
`default_nettype none
module port_a_b_pin_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, pact = 1'b0, wrq, chg, t0;
	logic [5:0] adr = 6'h00, ea = 6'h00, ena = 6'h00, pa, oa, oea, pua;
	logic [7:0] eb = 8'h00, enb = 8'h00, pb, ob, oeb, oaa, oab, v, s;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [3:0] be = 4'hF;
	logic [1:0] pout = 2'h0, poe = 2'h0;
	int error_cnt = 0, checks = 0, cyc = 0;
	// 100 MHz core clock
	always #5 clk = ~clk;
	gpab_port DUT (.i_core_clk(clk), .i_reset_n(rst_n), .i_address(adr), .i_read(rd), .i_write(wr),
		.i_writedata(wd), .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wrq), .i_pin_a(pa),
		.i_pin_b(pb), .o_pin_out_a(oa), .o_pin_oe_a(oea), .o_pullup_on_a(pua), .o_pin_out_b(ob),
		.o_pin_oe_b(oeb), .i_prog_active(pact), .i_prog_out(pout), .i_prog_oe(poe), .o_change_int(chg),
		.o_timer0_ext_clock_in(t0), .o_analog_en_a(oaa), .o_analog_en_b(oab));
	gpab_pins_model pins (.i_clk(clk), .i_out_a(oa), .i_oe_a(oea), .i_pu_a(pua), .i_out_b(ob),
		.i_oe_b(oeb), .i_ext_a(ea), .i_ext_en_a(ena), .i_ext_b(eb), .i_ext_en_b(enb), .o_pad_a(pa), .o_pad_b(pb));
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard: the whole sequence needs well under this
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
		rd <= ~w;
		wr <= w;
		adr <= {i, 2'h0};
		wd <= {24'h000000, d};
		@(posedge clk);
		while (wrq !== 1'b0) @(posedge clk);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wreg(input logic [3:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask
	task automatic rchk(input string nm, input logic [3:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(nm, q, {24'h000000, e});
	endtask
	// Pin paths pass two synchronisers and an output register
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask
	initial begin
		void'($urandom(34444));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk("pullup_a", `GPAB_OFS_PULLUP_A, 8'h3F);
		rchk("chg_en_a", `GPAB_OFS_CHGEN_A, 8'h00);
		rchk("ansel_a", `GPAB_OFS_ANSEL_A, 8'h17);
		rchk("dir_b", `GPAB_OFS_DIR_B, 8'hF0);
		rchk("unmapped", 4'hA, 8'h00);
		wreg(`GPAB_OFS_PULLUP_A, 8'hFF);
		rchk("pullup_a", `GPAB_OFS_PULLUP_A, 8'h3F);
		wreg(`GPAB_OFS_CHGEN_A, 8'hFF);
		rchk("chg_en_a", `GPAB_OFS_CHGEN_A, 8'h3F);
		wreg(`GPAB_OFS_ANSEL_A, 8'hE8);
		rchk("ansel_a", `GPAB_OFS_ANSEL_A, 8'h00);
		be <= 4'h0;
		wreg(`GPAB_OFS_ANSEL_A, 8'h17);
		rchk("ansel_a", `GPAB_OFS_ANSEL_A, 8'h00);
		be <= 4'hF;
		wreg(`GPAB_OFS_CHGEN_A, 8'h00);
		wreg(`GPAB_OFS_CTRL, 8'h00);
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			wreg(`GPAB_OFS_PULLUP_A, v);
			settle(2);
			chk("pullup_on", pua, v[5:0]);
		end
		wreg(`GPAB_OFS_CTRL, 8'h01);
		settle(2);
		chk("pullup_on", pua, 6'h00);
		wreg(`GPAB_OFS_PULLUP_A, 8'h00);
		wreg(`GPAB_OFS_CTRL, 8'h04);
		settle(2);
		chk("pullup_on", pua, 6'h08);
		wreg(`GPAB_OFS_PULLUP_A, 8'h3F);
		wreg(`GPAB_OFS_DIR_A, 8'h3E);
		settle(2);
		chk("pullup_on", pua, 6'h3E);
		// Analog pins stay inputs, as software must keep them
		wreg(`GPAB_OFS_DIR_A, 8'h3F);
		ena <= 6'h3F;
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			s = $urandom;
			ea <= v[5:0];
			wreg(`GPAB_OFS_ANSEL_A, s);
			settle(6);
			rchk("data_a", `GPAB_OFS_DATA_A, v & 8'h3F & ~(s & 8'h17));
			chk("analog_a", oaa, s & 8'h17);
			chk("pullup_on", pua, 6'h3F);
		end
		// Pin 2 as analog output also clocks the timer
		ena <= 6'h3B;
		wreg(`GPAB_OFS_ANSEL_A, 8'h04);
		wreg(`GPAB_OFS_DIR_A, 8'h3B);
		for (int i = 0; i < 2; i++) begin
			v = (i == 0) ? 8'h04 : 8'h00;
			wreg(`GPAB_OFS_DATA_A, v);
			settle(6);
			chk("oe_a", oea, 6'h04);
			chk("out_a2", oa[2], v[2]);
			chk("timer0", t0, v[2]);
		end
		ena <= 6'h38;
		pact <= 1'b1;
		pout <= 2'h2;
		poe <= 2'h3;
		settle(2);
		chk("prog_oe", oea[1:0], 2'h3);
		chk("prog_out", oa[1:0], 2'h2);
		pact <= 1'b0;
		wreg(`GPAB_OFS_DIR_B, 8'h00);
		wreg(`GPAB_OFS_DATA_B, 8'hA5);
		settle(2);
		chk("out_b", ob[7:4], 4'hA);
		chk("oe_b", oeb, 8'hF0);
		wreg(`GPAB_OFS_DIR_B, 8'hF0);
		enb <= 8'hFF;
		v = $urandom;
		eb <= v;
		settle(6);
		chk("oe_b", oeb, 8'h00);
		rchk("data_b", `GPAB_OFS_DATA_B, v & 8'hC0);
		chk("analog_b", oab, 8'h30);
		wreg(`GPAB_OFS_ANSEL_B, 8'h00);
		settle(6);
		rchk("data_b", `GPAB_OFS_DATA_B, v & 8'hF0);
		chk("analog_b", oab, 8'h00);
		// Change detection on pin 0 only
		wreg(`GPAB_OFS_DIR_A, 8'h3F);
		ena <= 6'h3F;
		ea <= 6'h00;
		wreg(`GPAB_OFS_ANSEL_A, 8'h00);
		wreg(`GPAB_OFS_CHGEN_A, 8'h01);
		wreg(`GPAB_OFS_CTRL, 8'h02);
		settle(6);
		rchk("data_a", `GPAB_OFS_DATA_A, 8'h00);
		wreg(`GPAB_OFS_STATUS, 8'h01);
		ea <= 6'h02;
		settle(6);
		chk("chg_int", chg, 1'b0);
		ea <= 6'h03;
		settle(6);
		chk("chg_int", chg, 1'b1);
		rchk("data_a", `GPAB_OFS_DATA_A, 8'h03);
		wreg(`GPAB_OFS_STATUS, 8'h01);
		settle(2);
		chk("chg_int", chg, 1'b0);
		wreg(`GPAB_OFS_CTRL, 8'h00);
		ea <= 6'h02;
		settle(6);
		chk("chg_int", chg, 1'b0);
		rchk("flag", `GPAB_OFS_STATUS, 8'h01);
		// A second reset must keep the last-read value
		rst_n <= 1'b0;
		settle(2);
		rst_n <= 1'b1;
		@(posedge clk);
		wreg(`GPAB_OFS_CHGEN_A, 8'h01);
		settle(6);
		rchk("flag", `GPAB_OFS_STATUS, 8'h01);
		final_report();
	end
endmodule
`default_nettype wire
